// ---- dfsa_pkg.sv ----
// Package for the frame-sync converter serial port.
// Assumes one 250 MHz system clock; serial pins sampled synchronously.
package dfsa_pkg;
   // ----------------------------------------
   // Widths and counts
   // ----------------------------------------
   localparam int DFSA_RESULT_W = 14;
   localparam logic [3:0] DFSA_LAST_BIT = 4'hD;
   localparam logic [4:0] DFSA_CONV_CLKS = 5'h0A;
   localparam logic [13:0] DFSA_RESULT_RST = 14'h0000;

   typedef enum logic [2:0] {
      DFSA_SLEEP,
      DFSA_OTHER_MODE,
      DFSA_IDLE,
      DFSA_CONVERT,
      DFSA_SHIFT
   } dfsa_state_t;
endpackage

// ---- dfsa_edge.sv ----
// Edge detector for one synchronous input pin.
// Assumes the pin is already synchronous to clock.
`timescale 1ns/1ps
module dfsa_edge (
   input wire logic clock,
   input wire logic nrst,
   input wire logic pin,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic prev;
   } dfsa_edge_st_t;

   dfsa_edge_st_t st_r;
   dfsa_edge_st_t st_nxt;

   always_comb begin
      st_nxt.prev = pin;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rise = pin & ~st_r.prev;
   assign fall = ~pin & st_r.prev;
endmodule

// ---- dfsa_port.sv ----
// Serial port of a 14-bit converter in DSP frame-sync mode.
// Assumes a DSP master drives sclk, csN and frameSyncIn synchronously to clock,
// and that the analog core delivers a result on convResult when asked.
//
// How it works
// - Conversion timed only by external serial clock
// - Falling select edge wakes from sleep
// - Frame-sync level sampled at select fall
// - Frame-sync low at select fall: DSP mode
// - Select may stay low; mode persists
// - Frame-sync pulse starts a conversion
// - Outgoing frame-sync marks MSB on data
// - No channel scanning in DSP mode
// - Serial clock shifts all data
// - Data changes on serial clock falling edge
`timescale 1ns/1ps
module dfsa_port (
   input wire logic clock,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic csN,
   input wire logic frameSyncIn,
   input wire logic [dfsa_pkg::DFSA_RESULT_W-1:0] convResult,
   output logic convStart,
   output logic dspMode,
   output logic frameSyncOut,
   output logic dataOut
);
   import dfsa_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      dfsa_state_t state;
      logic [4:0] clkCnt;
      logic [3:0] bitCnt;
      logic [DFSA_RESULT_W-1:0] shift;
      logic convStart;
      logic dspMode;
      logic frameSyncOut;
      logic dataOut;
   } dfsa_st_t;

   dfsa_st_t st_r;
   dfsa_st_t st_nxt;
   logic sclkRise;
   logic sclkFall;
   logic csFall;

   dfsa_edge uSclk (
      .clock(clock),
      .nrst(nrst),
      .pin(sclk),
      .rise(sclkRise),
      .fall(sclkFall)
   );

   dfsa_edge uCs (
      .clock(clock),
      .nrst(nrst),
      .pin(csN),
      .rise(),
      .fall(csFall)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.convStart = 1'b0;
      if (csFall) begin
         // Mode chosen from frame-sync level at the select edge
         if (!frameSyncIn) begin
            st_nxt.state = DFSA_IDLE;
            st_nxt.dspMode = 1'b1;
         end else begin
            st_nxt.state = DFSA_OTHER_MODE;
            st_nxt.dspMode = 1'b0;
         end
         st_nxt.frameSyncOut = 1'b0;
         st_nxt.dataOut = 1'b0;
      end else begin
         case (st_r.state)
            DFSA_SLEEP: begin
               st_nxt.dspMode = 1'b0;
            end
            DFSA_OTHER_MODE: begin
               st_nxt.dspMode = 1'b0;
            end
            DFSA_IDLE: begin
               // Select level ignored here: it may stay low forever
               if (frameSyncIn && sclkRise) begin
                  st_nxt.state = DFSA_CONVERT;
                  st_nxt.convStart = 1'b1;
                  st_nxt.clkCnt = '0;
               end
            end
            DFSA_CONVERT: begin
               // Conversion paced by serial clock edges, no internal oscillator
               if (sclkFall) begin
                  if (st_r.clkCnt == DFSA_CONV_CLKS) begin
                     st_nxt.state = DFSA_SHIFT;
                     st_nxt.shift = convResult;
                     st_nxt.dataOut = convResult[DFSA_RESULT_W-1];
                     st_nxt.frameSyncOut = 1'b1;
                     st_nxt.bitCnt = '0;
                  end else begin
                     st_nxt.clkCnt = st_r.clkCnt + 5'h01;
                  end
               end
            end
            DFSA_SHIFT: begin
               if (sclkFall) begin
                  st_nxt.frameSyncOut = 1'b0;
                  if (st_r.bitCnt == DFSA_LAST_BIT) begin
                     st_nxt.state = DFSA_IDLE;
                     st_nxt.dataOut = 1'b0;
                  end else begin
                     st_nxt.shift = {st_r.shift[DFSA_RESULT_W-2:0], 1'b0};
                     st_nxt.dataOut = st_r.shift[DFSA_RESULT_W-2];
                     st_nxt.bitCnt = st_r.bitCnt + 4'h1;
                  end
               end
            end
            default: begin
               st_nxt.state = DFSA_SLEEP;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st_r.state <= DFSA_SLEEP;
         st_r.clkCnt <= '0;
         st_r.bitCnt <= '0;
         st_r.shift <= DFSA_RESULT_RST;
         st_r.convStart <= 1'b0;
         st_r.dspMode <= 1'b0;
         st_r.frameSyncOut <= 1'b0;
         st_r.dataOut <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign convStart = st_r.convStart;
   assign dspMode = st_r.dspMode;
   assign frameSyncOut = st_r.frameSyncOut;
   assign dataOut = st_r.dataOut;
endmodule

// ---- dfsa_properties.sv ----
// Port checker.
// Sees only the dfsa_port pins.
`timescale 1ns/1ps
module dfsa_chk (
   input wire logic clock,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic csN,
   input wire logic frameSyncIn,
   input wire logic convStart,
   input wire logic dspMode,
   input wire logic frameSyncOut,
   input wire logic dataOut
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!nrst);
   sequence fsoHeld;
      frameSyncOut [*4];
   endsequence
   chk_mode_in: assert property ($fell(csN) && !frameSyncIn |=> dspMode)
      else $error("bad");
   chk_mode_out: assert property ($fell(csN) && frameSyncIn |=> !dspMode)
      else $error("bad");
   chk_mode_hold: assert property (dspMode && !$fell(csN) |=> dspMode)
      else $error("bad");
   chk_start_cause: assert property (convStart |-> $past(frameSyncIn) && dspMode)
      else $error("bad");
   chk_start_once: assert property (convStart |=> !convStart)
      else $error("bad");
   chk_fso_held: assert property ($rose(frameSyncOut) |-> !sclk ##0 fsoHeld)
      else $error("bad");
   chk_data_edge: assert property ($changed(dataOut) |-> !sclk)
      else $error("bad");
   chk_idle_quiet: assert property (!dspMode |-> !convStart && !frameSyncOut)
      else $error("bad");
endmodule
bind dfsa_port dfsa_chk i_chk (.*);

// ---- dfsa_host.sv ----
// DSP host model: select, frame sync, sclk.
// Assumes the port samples its pins on clock.
`timescale 1ns/1ps
module dfsa_host (
   input wire logic clock,
   input wire logic frameSyncOut,
   input wire logic dataOut,
   output logic sclk,
   output logic csN,
   output logic frameSyncIn
);
   logic [13:0] rxWord;
   int n = 0;
   initial {sclk, csN, frameSyncIn} = 3'b010;
   task automatic wake(input logic fs);
      @(posedge clock) csN <= 1'b1;
      frameSyncIn <= fs;
      @(posedge clock) csN <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   // Sclk stands low between frames
   task automatic frame(input logic fs);
      n = 0;
      frameSyncIn <= fs;
      for (int i = 0; i < 28; i++) begin
         @(posedge clock) sclk <= 1'b1;
         repeat (3) @(posedge clock);
         if (frameSyncOut || (n > 0 && n < 14)) begin
            rxWord = {rxWord[12:0], dataOut};
            n = frameSyncOut ? 1 : n + 1;
         end
         frameSyncIn <= 1'b0;
         sclk <= 1'b0;
         repeat (3) @(posedge clock);
      end
   endtask
endmodule

// ---- dfsa_port_tb.sv ----
// Bench for dfsa_port.
// Host model drives the serial pins.
`timescale 1ns/1ps
module dfsa_port_tb;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [13:0] convResult = 14'h0000;
   logic sclk, csN, frameSyncIn, convStart, dspMode, frameSyncOut, dataOut;
   logic [13:0] rows [3] = '{14'h3FFF, 14'h2AAA, 14'h1555};
   int mismatches = 0;
   int checksDone = 0;
   int cycles = 0;
   int starts = 0;
   dfsa_port i_dut (.*);
   dfsa_host i_host (.*);
   always #2 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (convStart === 1'b1) begin
         starts++;
      end
      if (cycles == 5000) begin
         mismatches++;
         results();
      end
   end
   task automatic check(input logic [13:0] got, want);
      checksDone++;
      if (got !== want) begin
         mismatches++;
         $display("Error %0t: bad value", $time);
      end
   endtask
   task automatic results;
      $display("%0d checks %0d mismatches", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      i_host.wake(1'b0);
      check(14'(dspMode), 14'h0001);
      foreach (rows[i]) begin
         convResult <= rows[i];
         i_host.frame(1'b1);
         check(i_host.rxWord, rows[i]);
         check(14'(dataOut), 14'h0000);
         check(14'(starts), 14'(i + 1));
      end
      $display("table done");
      i_host.frame(1'b0);
      check(14'(i_host.n), 14'h0000);
      check(14'(starts), 14'h0003);
      i_host.wake(1'b1);
      check(14'(dspMode), 14'h0000);
      i_host.frame(1'b1);
      check(14'(i_host.n), 14'h0000);
      check(14'(starts), 14'h0003);
      $display("refusals done");
      i_host.wake(1'b0);
      check(14'(dspMode), 14'h0001);
      nrst <= 1'b0;
      @(posedge clock);
      check(14'(dspMode), 14'h0000);
      check(14'(frameSyncOut), 14'h0000);
      nrst <= 1'b1;
      $display("reset done");
      results();
   end
endmodule
